// ---- hdl/core_map_pkg.sv ----
// Constants and carrier types for the core memory map block
package core_map_pkg;
   // ----------------------------------------
   // Register offsets (byte addresses are four times these indices)
   // ----------------------------------------
   localparam logic [7:0] IDX_INDIRECT_ACCESS_PORT = 8'h00;
   localparam logic [7:0] IDX_TIMER_ZERO_COUNT     = 8'h01;
   localparam logic [7:0] IDX_PROGRAM_COUNTER_LOW  = 8'h02;
   localparam logic [7:0] IDX_CORE_FLAGS           = 8'h03;
   localparam logic [7:0] IDX_INDIRECT_POINTER     = 8'h04;
   localparam logic [7:0] IDX_FIRST_IO_PORT        = 8'h05;
   localparam logic [7:0] IDX_SECOND_IO_PORT       = 8'h06;
   localparam logic [7:0] IDX_THIRD_IO_PORT        = 8'h07;
   localparam logic [7:0] IDX_PROGRAM_COUNTER_HIGH = 8'h0A;
   localparam logic [7:0] IDX_PROG_ADDR            = 8'h40;
   localparam logic [7:0] IDX_PROG_DATA            = 8'h41;
   localparam logic [7:0] IDX_PC_CONTROL           = 8'h42;
   localparam logic [7:0] IDX_RAM_FIRST            = 8'h20;
   localparam logic [7:0] IDX_RAM_LAST             = 8'h7F;
   // ----------------------------------------
   // Widths, ranges and vectors
   // ----------------------------------------
   localparam int         PC_WIDTH      = 13;
   localparam int         PROG_AW       = 11;
   localparam int         PROG_DW       = 14;
   localparam int         PROG_DEPTH    = 2048;
   localparam logic [12:0] RESET_VECTOR = 13'h0000;
   localparam logic [12:0] INT_VECTOR   = 13'h0004;
   localparam logic [12:0] PROG_LAST    = 13'h07FF;
   localparam int         RAM_DEPTH     = 128;
   // ----------------------------------------
   // Reset values and field positions
   // ----------------------------------------
   localparam logic [7:0] RST_ZERO       = 8'h00;
   localparam logic [7:0] RST_CORE_FLAGS = 8'h18;
   localparam logic [7:0] FLAGS_WR_MASK  = 8'hE0;
   localparam int         PCCTL_STEP_BIT = 0;
   localparam int         PCCTL_INT_BIT  = 1;
   localparam logic [7:0] FIRST_PORT_MASK = 8'h3F;
   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] out_q;
      logic [7:0] dir_n_q;
   } port_pins_type;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_ACCESS = 3'b010,
      ST_DONE   = 3'b100
   } apb_state_type;
endpackage

// ---- hdl/core_memory_map.sv ----
// Core memory map: program store, data memory, core registers on APB
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module core_memory_map
   import core_map_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Core side: fetch port on its own bus
   output logic      [12:0] fetch_pc,
   output logic      [13:0] fetch_word,
   // I/O pins
   input  wire logic [7:0]  first_io_in,
   input  wire logic [7:0]  second_io_in,
   input  wire logic [7:0]  third_io_in,
   output logic      [7:0]  first_io_out,
   output logic      [7:0]  second_io_out,
   output logic      [7:0]  third_io_out
);
   // ----------------------------------------
   // Storage
   // ----------------------------------------
   // Memories: program store and general purpose RAM
   logic [13:0] prog_mem [PROG_DEPTH];
   logic [7:0]  data_mem [RAM_DEPTH];
   // Core registers
   logic [12:0] pc_q;
   logic [12:0] prog_addr_q;
   logic [7:0]  flags_q;
   logic [7:0]  timer_q;
   logic [7:0]  pointer_q;
   logic [7:0]  pc_high_q;
   // Bus answer and fetch pipeline
   logic [7:0]  prdata_q;
   logic [13:0] fetch_word_q;
   logic        err_q;
   apb_state_type state_q;
   // Port latches and pin synchronisers
   port_pins_type first_q;
   port_pins_type second_q;
   port_pins_type third_q;
   logic [7:0]  first_s1_q, first_s2_q, first_s3_q, first_pin_q;
   logic [7:0]  second_s1_q, second_s2_q, second_s3_q, second_pin_q;
   logic [7:0]  third_s1_q, third_s2_q, third_s3_q, third_pin_q;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Fold any counter value onto the implemented store
   function automatic logic [PROG_AW-1:0] wrap_addr(input logic [12:0] a);
      wrap_addr = a[PROG_AW-1:0];
   endfunction

   // Resolve address zero through the pointer
   // A pointer of zero lands on index zero again: reads zero, writes nothing
   function automatic logic [7:0] eff_addr(input logic [7:0] a, input logic [7:0] p);
      eff_addr = (a == IDX_INDIRECT_ACCESS_PORT) ? p : a;
   endfunction

   // True for the general purpose RAM window
   function automatic logic in_ram(input logic [7:0] a);
      in_ram = (a >= IDX_RAM_FIRST) && (a <= IDX_RAM_LAST);
   endfunction

   // True for the program store window; these indices shadow RAM when
   // addressed directly, so RAM there answers only through the pointer
   function automatic logic prog_port(input logic [7:0] a);
      prog_port = (a >= IDX_PROG_ADDR) && (a <= IDX_PC_CONTROL);
   endfunction

   // Per-bit vote: a bit moves only when the last two stages agree,
   // otherwise it keeps its level, so one unsettled stage is ignored
   function automatic logic [7:0] vote(input logic [7:0] s2, input logic [7:0] s3,
                                       input logic [7:0] held);
      vote = (s2 & s3) | (held & (s2 | s3));
   endfunction

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   // Bus map, byte address four times the index:
   //   0x000-0x01C  core registers; index zero resolves through the pointer
   //   0x028        holding register for the upper five counter bits
   //   0x080-0x1FC  general purpose RAM
   //   0x100        program store address, used by later data accesses
   //   0x104        program store data; reads give only bits 5:0
   //   0x108        counter control: bit 0 steps, bit 1 jumps to the vector
   // The program window overlaps three RAM indices; direct accesses there
   // go to the program side and those cells answer only through the
   // pointer. Anything else, or nonzero paddr[11:10] or [1:0], is refused.
   logic       setup;
   logic       wr_go;
   logic [7:0] idx;
   logic [7:0] eidx;
   logic       mapped;
   logic       word_ok;
   // Setup is only taken from idle, so a stray setup mid-transfer is ignored
   assign setup   = psel && !penable && (state_q == ST_IDLE);
   assign idx     = paddr[9:2];
   assign word_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
   assign eidx    = eff_addr(idx, pointer_q);
   // Index zero inside the pointer loops back; treat it as reading zero
   assign mapped  = word_ok && ((eidx <= IDX_THIRD_IO_PORT) ||
                    (eidx == IDX_PROGRAM_COUNTER_HIGH) ||
                    in_ram(eidx) || prog_port(idx));
   // Write strobe: a mapped setup edge with the clock enabled
   assign wr_go   = clk_en && setup && pwrite && mapped;
   assign pready  = (state_q == ST_DONE);
   assign prdata  = {24'h000000, prdata_q};
   assign pslverr = pready && err_q;

   // Bus handshake: one access cycle, answer the cycle after
   // Latency is fixed at two edges after setup so a master needs no
   // wait logic; clk_en low stretches access and done, but a setup edge with clk_en low is lost and the transfer stalls
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         err_q   <= 1'b0;
      end else if (clk_en) begin
         case (state_q)
            ST_IDLE: begin
               if (setup) begin
                  state_q <= ST_ACCESS;
                  err_q   <= !mapped;
               end
            end
            // Access: read data is captured here
            ST_ACCESS: state_q <= ST_DONE;
            // Done: pready stands for this one cycle
            ST_DONE:   state_q <= ST_IDLE;
            default:   state_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Pin synchronisers, three stages, agreement of last two
   // ----------------------------------------
   // The vote adds one more flop, so a pin change shows up four
   // enabled edges later; only the second stage reads the first
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         first_s1_q  <= RST_ZERO;
         first_s2_q  <= RST_ZERO;
         first_s3_q  <= RST_ZERO;
         first_pin_q <= RST_ZERO;
         second_s1_q <= RST_ZERO;
         second_s2_q <= RST_ZERO;
         second_s3_q <= RST_ZERO;
         second_pin_q <= RST_ZERO;
         third_s1_q  <= RST_ZERO;
         third_s2_q  <= RST_ZERO;
         third_s3_q  <= RST_ZERO;
         third_pin_q <= RST_ZERO;
      end else if (clk_en) begin
         first_s1_q  <= first_io_in;
         first_s2_q  <= first_s1_q;
         first_s3_q  <= first_s2_q;
         second_s1_q <= second_io_in;
         second_s2_q <= second_s1_q;
         second_s3_q <= second_s2_q;
         third_s1_q  <= third_io_in;
         third_s2_q  <= third_s1_q;
         third_s3_q  <= third_s2_q;
         // Bitwise: take a bit only once two stages agree
         first_pin_q  <= vote(first_s2_q, first_s3_q, first_pin_q);
         second_pin_q <= vote(second_s2_q, second_s3_q, second_pin_q);
         third_pin_q  <= vote(third_s2_q, third_s3_q, third_pin_q);
      end
   end

   // ----------------------------------------
   // Core registers
   // ----------------------------------------
   // Writes land on the setup edge so a read in the next transfer sees new state
   // The timer is a plain software register here; nothing makes it count
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         timer_q   <= RST_ZERO;
         flags_q   <= RST_CORE_FLAGS;
         pointer_q <= RST_ZERO;
         pc_high_q <= RST_ZERO;
         first_q   <= '0;
         second_q  <= '0;
         third_q   <= '0;
         prog_addr_q <= RESET_VECTOR;
      end else if (wr_go) begin
         case (eidx)
            IDX_TIMER_ZERO_COUNT: timer_q <= pwdata[7:0];
            // Only bank bits are writable; arithmetic and reset flags stay
            IDX_CORE_FLAGS:
               flags_q <= (flags_q & ~FLAGS_WR_MASK) | (pwdata[7:0] & FLAGS_WR_MASK);
            IDX_INDIRECT_POINTER:     pointer_q <= pwdata[7:0];
            // Upper five counter bits only; the rest read as zero
            IDX_PROGRAM_COUNTER_HIGH: pc_high_q <= {3'b000, pwdata[4:0]};
            // First port is six bits wide
            IDX_FIRST_IO_PORT:        first_q.out_q <= pwdata[7:0] & FIRST_PORT_MASK;
            IDX_SECOND_IO_PORT:       second_q.out_q <= pwdata[7:0];
            IDX_THIRD_IO_PORT:        third_q.out_q <= pwdata[7:0];
            default: begin
               if (idx == IDX_PROG_ADDR) begin
                  prog_addr_q <= pwdata[12:0];
               end
            end
         endcase
      end
   end

   // Program counter: reset vector, interrupt vector, step, low-byte write
   // A low-byte write pulls the upper bits from the holding register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pc_q <= RESET_VECTOR;
      end else if (wr_go && idx == IDX_PC_CONTROL && pwdata[PCCTL_INT_BIT]) begin
         pc_q <= INT_VECTOR;
      end else if (wr_go && idx == IDX_PC_CONTROL && pwdata[PCCTL_STEP_BIT]) begin
         pc_q <= pc_q + 13'h0001;
      end else if (wr_go && eidx == IDX_PROGRAM_COUNTER_LOW) begin
         pc_q <= {pc_high_q[4:0], pwdata[7:0]};
      end
   end

   // Program store on its own port; fetch runs alongside data accesses
   // Writes go to the word picked by the last address write
   always_ff @(posedge clk) begin
      if (wr_go && idx == IDX_PROG_DATA) begin
         prog_mem[wrap_addr(prog_addr_q)] <= pwdata[PROG_DW-1:0];
      end
   end

   // Fetch word trails the counter by one edge; after reset it shows 0 once
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fetch_word_q <= 14'h0000;
      end else if (clk_en) begin
         fetch_word_q <= prog_mem[wrap_addr(pc_q)];
      end
   end

   // General purpose RAM, separate from the program bus
   always_ff @(posedge clk) begin
      if (wr_go && in_ram(eidx) && !prog_port(idx)) begin
         data_mem[eidx[6:0]] <= pwdata[7:0];
      end
   end

   // ----------------------------------------
   // Read path, captured in the access cycle
   // ----------------------------------------
   // Program data reads give only six bits; the full word is write-only
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prdata_q <= RST_ZERO;
      end else if (clk_en && state_q == ST_ACCESS) begin
         if (pwrite || err_q) begin
            prdata_q <= RST_ZERO;
         end else if (idx == IDX_PROG_ADDR) begin
            prdata_q <= prog_addr_q[7:0];
         end else if (idx == IDX_PROG_DATA) begin
            prdata_q <= {2'b00, prog_mem[wrap_addr(prog_addr_q)][5:0]};
         end else if (idx == IDX_PC_CONTROL) begin
            prdata_q <= {3'b000, pc_q[12:8]};
         end else begin
            case (eidx)
               IDX_INDIRECT_ACCESS_PORT: prdata_q <= RST_ZERO;
               IDX_TIMER_ZERO_COUNT:     prdata_q <= timer_q;
               IDX_PROGRAM_COUNTER_LOW:  prdata_q <= pc_q[7:0];
               IDX_CORE_FLAGS:           prdata_q <= flags_q;
               IDX_INDIRECT_POINTER:     prdata_q <= pointer_q;
               IDX_FIRST_IO_PORT:        prdata_q <= first_pin_q & FIRST_PORT_MASK;
               IDX_SECOND_IO_PORT:       prdata_q <= second_pin_q;
               IDX_THIRD_IO_PORT:        prdata_q <= third_pin_q;
               IDX_PROGRAM_COUNTER_HIGH: prdata_q <= pc_high_q;
               default:                  prdata_q <= data_mem[eidx[6:0]];
            endcase
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign fetch_pc      = pc_q;
   assign fetch_word    = fetch_word_q;
   // Port outputs are the latches, never the pins
   assign first_io_out  = first_q.out_q;
   assign second_io_out = second_q.out_q;
   assign third_io_out  = third_q.out_q;
endmodule

// ---- sim/core_memory_map_checker.sv ----
// Concurrent checks on the core memory map ports
`timescale 1ns/1ps
module core_memory_map_checker
   import core_map_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        clk_en,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Fetch side
   input wire logic [12:0] fetch_pc
);
   // One clock domain, so one default clock and one disable
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Bus answer timing and qualification
   chk_ready_latency: assert property (psel && !penable && clk_en |-> ##2 pready)
      else $error("pready not two cycles after setup");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   chk_ready_in_access: assert property (pready |-> psel && penable)
      else $error("pready outside an access phase");
   chk_err_qualified: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned nonzero data");
   chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
      else $error("read data above the low byte is nonzero");
   // Program counter vectors and freeze
   chk_reset_vector: assert property ($rose(reset_n) |-> fetch_pc == RESET_VECTOR)
      else $error("fetch does not start at the reset vector");
   chk_int_vector: assert property (psel && !penable && pwrite && clk_en
      && paddr == {2'b00, IDX_PC_CONTROL, 2'b00} && pwdata[PCCTL_INT_BIT]
      |=> fetch_pc == INT_VECTOR)
      else $error("jump did not land on the interrupt vector");
   chk_freeze_pc: assert property (!clk_en |=> $stable(fetch_pc))
      else $error("program counter moved while frozen");

   // Main scenarios reached
   cov_write: cover property (pready && pwrite && !pslverr);
   cov_read: cover property (pready && !pwrite && !pslverr);
   cov_refused: cover property (pready && pslverr);
endmodule

bind core_memory_map core_memory_map_checker core_memory_map_checker_inst (.clk, .reset_n,
   .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fetch_pc);

// ---- sim/tb_top.sv ----
// Self-checking testbench for the core memory map block
`timescale 1ns/1ps
module tb_top;
   import core_map_pkg::*;
   logic        clk, reset_n, clk_en, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [12:0] fetch_pc;
   logic [13:0] fetch_word;
   logic [7:0]  io_in [3];
   logic [7:0]  io_out [3];
   int          mismatches, compares, cycles;
   logic [7:0]  idx_tab [5] = '{IDX_TIMER_ZERO_COUNT, IDX_PROGRAM_COUNTER_LOW, IDX_CORE_FLAGS,
                               IDX_INDIRECT_POINTER, IDX_INDIRECT_ACCESS_PORT};
   logic [7:0]  rst_tab [5] = '{RST_ZERO, RST_ZERO, RST_CORE_FLAGS, RST_ZERO, RST_ZERO};

   core_memory_map core_memory_map_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .fetch_pc(fetch_pc),
      .fetch_word(fetch_word), .first_io_in(io_in[0]), .second_io_in(io_in[1]),
      .third_io_in(io_in[2]), .first_io_out(io_out[0]), .second_io_out(io_out[1]),
      .third_io_out(io_out[2]));

   // --------------------------------
   // Bus tasks and comparison
   // --------------------------------
   function automatic logic [11:0] addr(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Request held until pready is sampled high at a rising edge; data and
   // error are taken at that same edge, and only then is the bus released
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      if (n >= 50) check(32'h0, 32'h1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic prog(input logic [31:0] a, input logic [31:0] w);
      xfer(1'b1, addr(IDX_PROG_ADDR), a);
      xfer(1'b1, addr(IDX_PROG_DATA), w);
   endtask
   task wrap_up;
      if (mismatches == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // --------------------------------
   // Clock, timeout and main sequence
   // --------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Whole run needs well under a thousand cycles, so this only trips on a hang
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up();
      end
   end
   initial begin
      reset_n = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      io_in = '{8'h00, 8'h00, 8'h00};
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         xfer(1'b0, addr(idx_tab[i]), 32'h0);
         check(rd, {24'h0, rst_tab[i]});
      end
      xfer(1'b1, addr(IDX_CORE_FLAGS), 32'hFF);
      xfer(1'b0, addr(IDX_CORE_FLAGS), 32'h0);
      check(rd, {24'h0, RST_CORE_FLAGS | FLAGS_WR_MASK});
      xfer(1'b1, addr(IDX_TIMER_ZERO_COUNT), 32'h96);
      xfer(1'b0, addr(IDX_TIMER_ZERO_COUNT), 32'h0);
      check(rd, 32'h96);
      // Indirect write lands in RAM; RAM cell keeps it for a direct read
      xfer(1'b1, addr(IDX_INDIRECT_POINTER), 32'h7F);
      xfer(1'b1, addr(IDX_INDIRECT_ACCESS_PORT), 32'hC3);
      xfer(1'b0, addr(IDX_RAM_LAST), 32'h0);
      check(rd, 32'hC3);
      xfer(1'b1, addr(IDX_RAM_LAST), 32'h5A);
      xfer(1'b0, addr(IDX_INDIRECT_ACCESS_PORT), 32'h0);
      check(rd, 32'h5A);
      // Ports: writes load latches, reads return synced pins
      for (int i = 0; i < 3; i++) begin
         xfer(1'b1, addr(IDX_FIRST_IO_PORT + 8'(i)), 32'hA5);
         io_in[i] <= 8'h3C ^ 8'(i);
         repeat (6) @(posedge clk);
         check(io_out[i], (i == 0) ? 8'hA5 & FIRST_PORT_MASK : 8'hA5);
         xfer(1'b0, addr(IDX_FIRST_IO_PORT + 8'(i)), 32'h0);
         check(rd, {24'h0, 8'h3C ^ 8'(i)});
      end
      // Program store: last word reached directly and through wraparound
      prog(32'h0, 32'h1234);
      prog(32'h7FF, 32'h2ABC);
      foreach (idx_tab[h]) if (h < 2) begin
         xfer(1'b1, addr(IDX_PROGRAM_COUNTER_HIGH), h ? 32'h0F : 32'h07);
         xfer(1'b1, addr(IDX_PROGRAM_COUNTER_LOW), 32'hFF);
         repeat (3) @(posedge clk);
         check(fetch_pc, h ? 32'h0FFF : 32'h07FF);
         check(fetch_word, 32'h2ABC);
      end
      xfer(1'b0, addr(IDX_PROGRAM_COUNTER_HIGH), 32'h0);
      check(rd, 32'h0F);
      xfer(1'b0, addr(IDX_PROG_ADDR), 32'h0);
      check(rd, 32'hFF);
      xfer(1'b0, addr(IDX_PROG_DATA), 32'h0);
      check(rd, 32'h3C);
      // RAM behind the program window is reached only through the pointer
      xfer(1'b1, addr(IDX_INDIRECT_POINTER), 32'h40);
      xfer(1'b1, addr(IDX_INDIRECT_ACCESS_PORT), 32'h66);
      xfer(1'b1, addr(IDX_PROG_ADDR), 32'h7FF);
      xfer(1'b0, addr(IDX_INDIRECT_ACCESS_PORT), 32'h0);
      check(rd, 32'h66);
      xfer(1'b0, addr(IDX_PC_CONTROL), 32'h0);
      check(rd, 32'h0F);
      xfer(1'b1, addr(IDX_PC_CONTROL), 32'h1);
      repeat (3) @(posedge clk);
      check(fetch_pc, 32'h1000);
      check(fetch_word, 32'h1234);
      xfer(1'b1, addr(IDX_PC_CONTROL), 32'h3);
      repeat (3) @(posedge clk);
      check(fetch_pc, INT_VECTOR);
      clk_en <= 1'b0;
      repeat (4) @(posedge clk);
      clk_en <= 1'b1;
      // Second reset in mid-run
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      check(fetch_pc, RESET_VECTOR);
      check(fetch_word, 32'h1234);
      check(io_out[2], 32'h0);
      // Refusals: unaligned and out-of-range addresses
      xfer(1'b0, 12'h011, 32'h0);
      check(err, 32'h1);
      xfer(1'b1, 12'h800 | addr(IDX_INDIRECT_POINTER), 32'h77);
      check(err, 32'h1);
      xfer(1'b0, addr(IDX_INDIRECT_POINTER), 32'h0);
      check(rd, 32'h0);
      wrap_up();
   end
endmodule
